//--- include/angle_module_pkg.sv
package angle_module_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;
  localparam int NCH    = 4;
  localparam int NCLASS = 4;

  // Status classes
  localparam int CLS_BIT = 0;
  localparam int CLS_SIG = 1;
  localparam int CLS_REF = 2;
  localparam int CLS_ANG = 3;

  // Register byte offsets, channel stride 2
  localparam logic [11:0] OFS_ACTIVE   = 12'h02E;
  localparam logic [11:0] OFS_MEASTYPE = 12'h03E;
  localparam logic [11:0] OFS_THRESH   = 12'h040;
  localparam logic [11:0] OFS_ALERTINI = 12'h04E;
  localparam logic [11:0] OFS_VELSCALE = 12'h0A0;
  localparam logic [11:0] OFS_ENCCFG   = 12'h0A8;
  localparam logic [11:0] OFS_FREQ     = 12'h0B0;
  localparam logic [11:0] OFS_AMPL     = 12'h0B2;
  localparam logic [11:0] OFS_ST_SIG   = 12'h0E8;
  localparam logic [11:0] OFS_ST_REF   = 12'h0EA;
  localparam logic [11:0] OFS_ST_BIT   = 12'h0EC;
  localparam logic [11:0] OFS_ST_ANG   = 12'h0F0;
  localparam logic [11:0] OFS_IE_SIG   = 12'h0F2;
  localparam logic [11:0] OFS_IE_REF   = 12'h0F4;
  localparam logic [11:0] OFS_IE_BIT   = 12'h0F6;
  localparam logic [11:0] OFS_IE_ANG   = 12'h0FA;
  localparam logic [11:0] OFS_DSGVER   = 12'h3B4;
  localparam logic [11:0] OFS_DSGREV   = 12'h3B6;
  localparam logic [11:0] OFS_FWREV    = 12'h3B8;
  localparam logic [11:0] OFS_LOGICREV = 12'h3BA;
  localparam logic [11:0] OFS_TYPEID   = 12'h3BC;

  // Field layout
  localparam int ENC_MODE_BIT = 15;
  localparam int ENC_SEL_W    = 3;
  localparam int SETTING_W    = 15;

  // Reset values
  localparam logic [15:0] RST_VELSCALE = 16'h0FFF;
  localparam logic [15:0] RST_ENCCFG   = 16'h0000;
  localparam logic [14:0] RST_FREQ     = 15'h0190;
  localparam logic [14:0] RST_AMPL     = 15'h0105;
  localparam logic [15:0] RST_THRESH   = 16'h0000;
  localparam logic [3:0]  RST_CHMASK   = 4'h0;

  // Velocity scaling: word = rate * scale / 4095
  localparam logic [45:0] VEL_RECIP = 46'h0000_0000_1001;
  localparam logic [45:0] VEL_ROUND = 46'h0000_0080_0000;
  localparam int          VEL_SHIFT = 24;

  // Loss qualification
  localparam int LOSS_TIME_MS = 2000;
  localparam int CLK_HZ       = 10_000_000;
  localparam int LOSS_CYCLES  = LOSS_TIME_MS * (CLK_HZ / 1000);
endpackage

//--- design/angle_module_config_status_regs.sv
`timescale 1ns/1ps
// Overview of operation
// - Per-channel 16-bit velocity scale factor
// - Scale changes only the reported velocity
// - Scale 4095 maps full rate to 7FFF/8000
// - Bit 15 picks encoder or commutation
// - Bits 3:0 pick synchro or resolver
// - Frequency 1 Hz per count, bit 15 unused
// - Amplitude 0.1 Vrms per count, bit 15 unused
// - Design version and revision read-only ASCII
// - Firmware and logic revisions read-only words
// - Type code read-only two ASCII characters
// - Test failure bits per channel, reset zero
// - Status latched, a read of that status register releases it
// - Loss flagged after two seconds absent
// - Loss monitoring suspended during initiated tests
// - Any loss event latches until read
// - Alert when angle moves past threshold
// - Per-class enables, one bit per channel, request one interrupt per class
// - Signal, reference, angle routed to vectors
// - Changes while latched held, loaded after read
// - Angle alert only for initiated channels
// - Threshold uses 16-bit angle weighting
module angle_module_config_status_regs
  import angle_module_pkg::*;
#(
  parameter int          LOSS_CNT  = angle_module_pkg::LOSS_CYCLES,
  parameter logic [15:0] DSGVER_ID = 16'h4141, // Arbitrary
  parameter logic [15:0] DSGREV_ID = 16'h4142, // Arbitrary
  parameter logic [15:0] FWREV_ID  = 16'h0001, // Arbitrary
  parameter logic [15:0] LOGREV_ID = 16'h0001, // Arbitrary
  parameter logic [15:0] TYPE_ID   = 16'h5858  // Arbitrary
) (
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  input  wire logic [angle_module_pkg::ADDR_W-1:0] busAddr,
  input  wire logic [angle_module_pkg::DATA_W-1:0] busWrData,
  input  wire logic                        busWrEn,
  input  wire logic                        busRdEn,
  output logic [angle_module_pkg::DATA_W-1:0]      busRdData,
  output logic                             busRdValid,
  input  wire logic [3:0]                  bitFailRaw,
  input  wire logic [3:0]                  signalPresent,
  input  wire logic [3:0]                  referencePresent,
  input  wire logic [3:0][15:0]            measuredAngle,
  input  wire logic [3:0][15:0]            trackRate,
  input  wire logic                        initiatedFullTest,
  input  wire logic                        initiatedFixedAngleTest,
  output logic [3:0][15:0]                 velocityWord,
  output logic [3:0]                       commutationMode,
  output logic [3:0][2:0]                  encoderSelect,
  output logic [3:0]                       synchroSelect,
  output logic [14:0]                      excitationFreq,
  output logic [14:0]                      excitationAmpl,
  output logic [3:0]                       activeChannelMask,
  output logic                             bitFailIrq,
  output logic                             openStatusIrq,
  output logic                             overCurrentIrq,
  output logic                             angleAlertVectorIrq
);
  import angle_module_pkg::*;

  localparam int CW = $clog2(LOSS_CNT + 1);

  if (LOSS_CNT < 2) begin : gChk
    $error("LOSS_CNT must be at least 2");
  end

  typedef struct packed {
    logic [3:0][15:0]        velScale;
    logic [3:0][15:0]        encCfg;
    logic [3:0]              measType;
    logic [14:0]             freq;
    logic [14:0]             ampl;
    logic [3:0]              activeMask;
    logic [3:0]              alertInit;
    logic [3:0][15:0]        thresh;
    logic [3:0][15:0]        refAngle;
    logic [3:0][3:0]         status;
    logic [3:0][3:0]         pending;
    logic [3:0][3:0]         irqEn;
    logic [7:0][CW-1:0]      lossCnt;
    logic [3:0][15:0]        velWord;
    logic [15:0]             rdData;
    logic                    rdValid;
    logic [3:0]              irq;
  } state_type;

  state_type st_ff;
  state_type nxt_st;

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [11:0] chanAddr(logic [11:0] base, int idx);
    chanAddr = base + 12'(2 * idx);
  endfunction

  function automatic logic [15:0] scaleVel(logic [15:0] rate,
                                           logic [15:0] scale);
    logic signed [45:0] p;
    logic signed [45:0] q;
    p = $signed({{30{rate[15]}}, rate}) * $signed({30'h0, scale});
    p = p * $signed(VEL_RECIP) + $signed(VEL_ROUND);
    q = p >>> VEL_SHIFT;
    if (q > 46'sd32767) begin
      scaleVel = 16'h7FFF;
    end else if (q < -46'sd32768) begin
      scaleVel = 16'h8000;
    end else begin
      scaleVel = q[15:0];
    end
  endfunction

  function automatic logic [15:0] angleDist(logic [15:0] a, logic [15:0] b);
    logic [15:0] d;
    d = a - b;
    angleDist = d[15] ? 16'(-d) : d;
  endfunction

  function automatic int statusClass(logic [11:0] a);
    unique case (a)
      OFS_ST_BIT: statusClass = CLS_BIT;
      OFS_ST_SIG: statusClass = CLS_SIG;
      OFS_ST_REF: statusClass = CLS_REF;
      OFS_ST_ANG: statusClass = CLS_ANG;
      default:    statusClass = -1;
    endcase
  endfunction

  function automatic int enableClass(logic [11:0] a);
    unique case (a)
      OFS_IE_BIT: enableClass = CLS_BIT;
      OFS_IE_SIG: enableClass = CLS_SIG;
      OFS_IE_REF: enableClass = CLS_REF;
      OFS_IE_ANG: enableClass = CLS_ANG;
      default:    enableClass = -1;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next state

  logic [3:0][3:0] events;
  logic            suspend;
  logic            lossNow;
  int              rdCls;
  int              wrCls;

  always_comb begin
    nxt_st  = st_ff;
    events  = '0;
    lossNow = 1'b0;
    suspend = initiatedFullTest | initiatedFixedAngleTest;
    rdCls   = busRdEn ? statusClass(busAddr) : -1;
    wrCls   = busWrEn ? enableClass(busAddr) : -1;

    // Velocity word only; tracking loop untouched
    for (int i = 0; i < NCH; i++) begin
      nxt_st.velWord[i] = scaleVel(trackRate[i], st_ff.velScale[i]);
    end

    // Test failures count only on active channels
    events[CLS_BIT] = bitFailRaw & st_ff.activeMask;

    // Loss qualification timers
    for (int i = 0; i < 2 * NCH; i++) begin
      lossNow = (i < NCH) ? !signalPresent[i % NCH]
                          : !referencePresent[i % NCH];
      if (suspend || !lossNow) begin
        nxt_st.lossCnt[i] = '0;
      end else if (st_ff.lossCnt[i] != CW'(LOSS_CNT)) begin
        nxt_st.lossCnt[i] = st_ff.lossCnt[i] + CW'(1);
      end
      if (st_ff.lossCnt[i] == CW'(LOSS_CNT) && lossNow && !suspend) begin
        if (i < NCH) begin
          events[CLS_SIG][i % NCH] = 1'b1;
        end else begin
          events[CLS_REF][i % NCH] = 1'b1;
        end
      end
    end

    // Angle change against the last reported angle
    for (int i = 0; i < NCH; i++) begin
      if (!st_ff.alertInit[i]) begin
        nxt_st.refAngle[i] = measuredAngle[i];
      end else if (angleDist(measuredAngle[i], st_ff.refAngle[i])
                   > st_ff.thresh[i]) begin
        events[CLS_ANG][i] = 1'b1;
        nxt_st.refAngle[i] = measuredAngle[i];
      end
    end

    // Latch, pend and release
    for (int c = 0; c < NCLASS; c++) begin
      if (rdCls == c) begin
        nxt_st.status[c]  = st_ff.pending[c] | events[c];
        nxt_st.pending[c] = '0;
      end else if (st_ff.status[c] == '0) begin
        nxt_st.status[c] = events[c];
      end else begin
        nxt_st.pending[c] = st_ff.pending[c] | events[c];
      end
    end

    // Register writes
    if (busWrEn) begin
      for (int i = 0; i < NCH; i++) begin
        if (busAddr == chanAddr(OFS_VELSCALE, i)) begin
          nxt_st.velScale[i] = busWrData;
        end
        if (busAddr == chanAddr(OFS_ENCCFG, i)) begin
          nxt_st.encCfg[i] = {busWrData[ENC_MODE_BIT], 12'h000,
                              busWrData[ENC_SEL_W-1:0]};
        end
        if (busAddr == chanAddr(OFS_THRESH, i)) begin
          nxt_st.thresh[i] = busWrData;
        end
      end
      unique case (busAddr)
        OFS_MEASTYPE: nxt_st.measType   = busWrData[3:0];
        OFS_FREQ:     nxt_st.freq       = busWrData[SETTING_W-1:0];
        OFS_AMPL:     nxt_st.ampl       = busWrData[SETTING_W-1:0];
        OFS_ACTIVE:   nxt_st.activeMask = busWrData[3:0];
        OFS_ALERTINI: nxt_st.alertInit  = busWrData[3:0];
        default: begin
        end
      endcase
      if (wrCls >= 0) begin
        nxt_st.irqEn[wrCls] = busWrData[3:0];
      end
    end

    // Register reads
    nxt_st.rdValid = busRdEn;
    nxt_st.rdData  = '0;
    if (busRdEn) begin
      for (int i = 0; i < NCH; i++) begin
        if (busAddr == chanAddr(OFS_VELSCALE, i)) begin
          nxt_st.rdData = st_ff.velScale[i];
        end
        if (busAddr == chanAddr(OFS_ENCCFG, i)) begin
          nxt_st.rdData = st_ff.encCfg[i];
        end
        if (busAddr == chanAddr(OFS_THRESH, i)) begin
          nxt_st.rdData = st_ff.thresh[i];
        end
      end
      unique case (busAddr)
        OFS_MEASTYPE: nxt_st.rdData = {12'h000, st_ff.measType};
        OFS_FREQ:     nxt_st.rdData = {1'b0, st_ff.freq};
        OFS_AMPL:     nxt_st.rdData = {1'b0, st_ff.ampl};
        OFS_ACTIVE:   nxt_st.rdData = {12'h000, st_ff.activeMask};
        OFS_ALERTINI: nxt_st.rdData = {12'h000, st_ff.alertInit};
        OFS_DSGVER:   nxt_st.rdData = DSGVER_ID;
        OFS_DSGREV:   nxt_st.rdData = DSGREV_ID;
        OFS_FWREV:    nxt_st.rdData = FWREV_ID;
        OFS_LOGICREV: nxt_st.rdData = LOGREV_ID;
        OFS_TYPEID:   nxt_st.rdData = TYPE_ID;
        default: begin
        end
      endcase
      if (rdCls >= 0) begin
        nxt_st.rdData = {12'h000, st_ff.status[rdCls]};
      end
      if (enableClass(busAddr) >= 0) begin
        nxt_st.rdData = {12'h000, st_ff.irqEn[enableClass(busAddr)]};
      end
    end

    // Interrupt requests per class
    for (int c = 0; c < NCLASS; c++) begin
      nxt_st.irq[c] = |(nxt_st.status[c] & nxt_st.irqEn[c]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff            <= '0;
      st_ff.velScale   <= {NCH{RST_VELSCALE}};
      st_ff.encCfg     <= {NCH{RST_ENCCFG}};
      st_ff.thresh     <= {NCH{RST_THRESH}};
      st_ff.freq       <= RST_FREQ;
      st_ff.ampl       <= RST_AMPL;
      st_ff.activeMask <= RST_CHMASK;
      st_ff.alertInit  <= RST_CHMASK;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign busRdData           = st_ff.rdData;
  assign busRdValid          = st_ff.rdValid;
  assign velocityWord        = st_ff.velWord;
  assign synchroSelect       = st_ff.measType;
  assign excitationFreq      = st_ff.freq;
  assign excitationAmpl      = st_ff.ampl;
  assign activeChannelMask   = st_ff.activeMask;
  assign bitFailIrq          = st_ff.irq[CLS_BIT];
  assign openStatusIrq       = st_ff.irq[CLS_SIG];
  assign overCurrentIrq      = st_ff.irq[CLS_REF];
  assign angleAlertVectorIrq = st_ff.irq[CLS_ANG];

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      commutationMode[i] = st_ff.encCfg[i][ENC_MODE_BIT];
      encoderSelect[i]   = st_ff.encCfg[i][ENC_SEL_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  chk_read_latch_value: assert property (
    @(posedge clk) disable iff (!rst_b)
    busRdEn && busAddr == OFS_ST_SIG
    |=> busRdValid && busRdData == {12'h000, $past(st_ff.status[CLS_SIG])})
    else $error("status read did not return latched value");

  chk_latch_hold: assert property (
    @(posedge clk) disable iff (!rst_b)
    st_ff.status[CLS_REF] != 4'h0 && !(busRdEn && busAddr == OFS_ST_REF)
    |=> st_ff.status[CLS_REF] == $past(st_ff.status[CLS_REF]))
    else $error("latched status changed without read");

  chk_loss_reset: assert property (
    @(posedge clk) disable iff (!rst_b)
    signalPresent[1] |=> st_ff.lossCnt[1] == '0)
    else $error("loss timer ran with signal present");

  chk_loss_suspend: assert property (
    @(posedge clk) disable iff (!rst_b)
    initiatedFullTest || initiatedFixedAngleTest |=> st_ff.lossCnt == '0)
    else $error("loss timers ran during initiated test");

  chk_loss_latch: assert property (
    @(posedge clk) disable iff (!rst_b)
    st_ff.lossCnt[NCH+2] == CW'(LOSS_CNT) && !referencePresent[2] && !suspend
    |=> st_ff.status[CLS_REF][2] || st_ff.pending[CLS_REF][2])
    else $error("qualified reference loss not latched");

  chk_vel_unity: assert property (
    @(posedge clk) disable iff (!rst_b)
    st_ff.velScale[0] == RST_VELSCALE
    |=> velocityWord[0] == $past(trackRate[0]))
    else $error("unity scale changed velocity word");

  chk_angle_masked: assert property (
    @(posedge clk) disable iff (!rst_b)
    !st_ff.alertInit[1] && st_ff.status[CLS_ANG][1] == 1'b0
    && st_ff.pending[CLS_ANG][1] == 1'b0
    |=> st_ff.status[CLS_ANG][1] == 1'b0)
    else $error("alert raised on uninitiated channel");

  chk_irq_route: assert property (
    @(posedge clk) disable iff (!rst_b)
    openStatusIrq == |(st_ff.status[CLS_SIG] & st_ff.irqEn[CLS_SIG])
    && angleAlertVectorIrq == |(st_ff.status[CLS_ANG] & st_ff.irqEn[CLS_ANG]))
    else $error("interrupt request does not match status and enable");

  chk_upper_zero: assert property (
    @(posedge clk) disable iff (!rst_b)
    busRdEn && (busAddr == OFS_IE_BIT || busAddr == OFS_ST_BIT)
    |=> busRdData[15:4] == 12'h000)
    else $error("upper status bits not zero");
endmodule

//--- sim/angle_host_model.sv
`timescale 1ns/1ps
module angle_host_model
  import angle_module_pkg::*;
(
  input  wire logic                                clk,
  output logic [angle_module_pkg::ADDR_W-1:0]      busAddr,
  output logic [angle_module_pkg::DATA_W-1:0]      busWrData,
  output logic                                     busWrEn,
  output logic                                     busRdEn,
  input  wire logic [angle_module_pkg::DATA_W-1:0] busRdData,
  input  wire logic                                busRdValid
);
  initial begin
    busAddr = 12'h000;
    busWrData = 16'h0000;
    busWrEn = 1'b0;
    busRdEn = 1'b0;
  end

  // Released lines show the inverse of the last value
  task automatic release_bus();
    busAddr = ~busAddr;
    busWrData = ~busWrData;
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    #1;
    busAddr = a;
    busWrData = d;
    busWrEn = 1'b1;
    @(posedge clk);
    #1;
    busWrEn = 1'b0;
    release_bus();
  endtask

  task automatic rd(input logic [11:0] a, output logic [15:0] d);
    @(posedge clk);
    #1;
    busAddr = a;
    busRdEn = 1'b1;
    @(posedge clk);
    #1;
    busRdEn = 1'b0;
    release_bus();
    d = (busRdValid === 1'b1) ? busRdData : 16'hxxxx;
  endtask
endmodule

//--- sim/angle_module_config_status_regs_test.sv
`timescale 1ns/1ps
module angle_module_config_status_regs_test;
  import angle_module_pkg::*;
  localparam int LCNT = 20;
  // Identity values are arbitrary
  localparam logic [15:0] IDS [5] = '{16'h4431, 16'h4432, 16'h0007,
                                       16'h0009, 16'h5A5A};
  logic             clk, rst_b, busWrEn, busRdEn, busRdValid;
  logic [11:0]      busAddr;
  logic [15:0]      busWrData, busRdData;
  logic [3:0]       bitFailRaw, signalPresent, referencePresent;
  logic [3:0][15:0] measuredAngle, trackRate, velocityWord;
  logic             initiatedFullTest, initiatedFixedAngleTest;
  logic [3:0]       commutationMode, synchroSelect, activeChannelMask;
  logic [3:0][2:0]  encoderSelect;
  logic [14:0]      excitationFreq, excitationAmpl;
  logic             bitFailIrq, openStatusIrq, overCurrentIrq;
  logic             angleAlertVectorIrq;
  int               errors = 0;
  int               checks = 0;
  int               cyc = 0;

  angle_module_config_status_regs #(.LOSS_CNT(LCNT), .DSGVER_ID(IDS[0]),
    .DSGREV_ID(IDS[1]), .FWREV_ID(IDS[2]), .LOGREV_ID(IDS[3]),
    .TYPE_ID(IDS[4])) DUT (.clk(clk), .rst_b(rst_b), .busAddr(busAddr),
    .busWrData(busWrData), .busWrEn(busWrEn), .busRdEn(busRdEn),
    .busRdData(busRdData), .busRdValid(busRdValid),
    .bitFailRaw(bitFailRaw), .signalPresent(signalPresent),
    .referencePresent(referencePresent), .measuredAngle(measuredAngle),
    .trackRate(trackRate), .initiatedFullTest(initiatedFullTest),
    .initiatedFixedAngleTest(initiatedFixedAngleTest),
    .velocityWord(velocityWord), .commutationMode(commutationMode),
    .encoderSelect(encoderSelect), .synchroSelect(synchroSelect),
    .excitationFreq(excitationFreq), .excitationAmpl(excitationAmpl),
    .activeChannelMask(activeChannelMask), .bitFailIrq(bitFailIrq),
    .openStatusIrq(openStatusIrq), .overCurrentIrq(overCurrentIrq),
    .angleAlertVectorIrq(angleAlertVectorIrq));

  angle_host_model host (.clk(clk), .busAddr(busAddr),
    .busWrData(busWrData), .busWrEn(busWrEn), .busRdEn(busRdEn),
    .busRdData(busRdData), .busRdValid(busRdValid));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic final_report();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      $display("mismatch at %0t: run too long", $time);
      final_report();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rdChk(input logic [11:0] a, input logic [15:0] exp);
    logic [15:0] v;
    host.rd(a, v);
    check(v, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    logic [11:0] ro [5] = '{OFS_DSGVER, OFS_DSGREV, OFS_FWREV,
                            OFS_LOGICREV, OFS_TYPEID};
    logic [11:0] st [8] = '{OFS_ST_BIT, OFS_ST_SIG, OFS_ST_REF, OFS_ST_ANG,
                            OFS_IE_BIT, OFS_IE_SIG, OFS_IE_REF, OFS_IE_ANG};
    rdChk(OFS_FREQ, 16'h0190);
    rdChk(OFS_AMPL, 16'h0105);
    for (int i = 0; i < 4; i++) begin
      rdChk(OFS_VELSCALE + 12'(2 * i), 16'h0FFF);
    end
    for (int i = 0; i < 8; i++) begin
      rdChk(st[i], 16'h0000);
    end
    for (int i = 0; i < 5; i++) begin
      host.wr(ro[i], ~IDS[i]);
      rdChk(ro[i], IDS[i]);
    end
    rdChk(12'h7F0, 16'h0000);
    $display("reset test done");
  endtask

  task automatic test_config();
    logic [15:0] v;
    for (int i = 0; i < 8; i++) begin
      v = (i < 5) ? 16'(i) : (16'h8000 | 16'(i - 5));
      host.wr(OFS_ENCCFG + 12'h006, v);
      idle(1);
      check({commutationMode[3], 12'h000, encoderSelect[3]}, v);
    end
    host.wr(OFS_ENCCFG, 16'h7FFC);
    rdChk(OFS_ENCCFG, 16'h0004);
    host.wr(OFS_MEASTYPE, 16'hFFFA);
    idle(1);
    check(16'(synchroSelect), 16'h000A);
    rdChk(OFS_MEASTYPE, 16'h000A);
    host.wr(OFS_FREQ, 16'hA710);
    host.wr(OFS_AMPL, 16'h8118);
    idle(1);
    check(16'(excitationFreq), 16'h2710);
    check(16'(excitationAmpl), 16'h0118);
    $display("config test done");
  endtask

  task automatic test_velocity();
    logic [15:0] sc [5] = '{16'h0FFF, 16'h0FFF, 16'h2FFD, 16'hFFF0, 16'hFFF0};
    logic [15:0] rt [5] = '{16'h7FFF, 16'h8000, 16'h0863, 16'h7FFF, 16'h8000};
    logic [15:0] ex [5] = '{16'h7FFF, 16'h8000, 16'h1929, 16'h7FFF, 16'h8000};
    for (int i = 0; i < 5; i++) begin
      host.wr(OFS_VELSCALE + 12'(2 * (i % 4)), sc[i]);
      trackRate[i % 4] = rt[i];
      idle(2);
      check(velocityWord[i % 4], ex[i]);
    end
    rdChk(OFS_VELSCALE + 12'h006, 16'hFFF0);
    $display("velocity test done");
  endtask

  task automatic test_bit();
    host.wr(OFS_ACTIVE, 16'h0003);
    host.wr(OFS_IE_BIT, 16'hFFF1);
    rdChk(OFS_IE_BIT, 16'h0001);
    rdChk(OFS_ACTIVE, 16'h0003);
    check(16'(activeChannelMask), 16'h0003);
    // One-cycle failure pulse, so nothing goes pending
    bitFailRaw = 4'h5;
    idle(1);
    bitFailRaw = 4'h0;
    idle(1);
    check(16'(bitFailIrq), 16'h0001);
    rdChk(OFS_ST_BIT, 16'h0001);
    rdChk(OFS_ST_BIT, 16'h0000);
    check(16'(bitFailIrq), 16'h0000);
    $display("selftest status test done");
  endtask

  task automatic test_loss();
    host.wr(OFS_IE_SIG, 16'h0002);
    host.wr(OFS_IE_REF, 16'h0004);
    signalPresent[1] = 1'b0;
    idle(LCNT - 5);
    signalPresent[1] = 1'b1;
    idle(2);
    rdChk(OFS_ST_SIG, 16'h0000);
    signalPresent[1] = 1'b0;
    idle(LCNT - 1);
    check(16'(openStatusIrq), 16'h0000);
    idle(2);
    check(16'(openStatusIrq), 16'h0001);
    signalPresent[1] = 1'b1;
    idle(2);
    rdChk(OFS_ST_SIG, 16'h0002);
    rdChk(OFS_ST_SIG, 16'h0000);
    for (int t = 0; t < 2; t++) begin
      initiatedFullTest = (t == 0);
      initiatedFixedAngleTest = (t == 1);
      referencePresent[2] = 1'b0;
      idle(LCNT + 5);
      check(16'(overCurrentIrq), 16'h0000);
      initiatedFullTest = 1'b0;
      initiatedFixedAngleTest = 1'b0;
      referencePresent[2] = 1'b1;
      idle(2);
      rdChk(OFS_ST_REF, 16'h0000);
    end
    referencePresent[2] = 1'b0;
    idle(LCNT + 1);
    check(16'(overCurrentIrq), 16'h0001);
    check(16'(openStatusIrq), 16'h0000);
    referencePresent[2] = 1'b1;
    idle(2);
    rdChk(OFS_ST_REF, 16'h0004);
    rdChk(OFS_ST_REF, 16'h0000);
    $display("loss test done");
  endtask

  task automatic test_angle();
    for (int i = 0; i < 3; i++) begin
      host.wr(OFS_THRESH + 12'(2 * i), 16'h0100);
    end
    host.wr(OFS_IE_ANG, 16'h0001);
    host.wr(OFS_ALERTINI, 16'h0003);
    measuredAngle[0] = 16'h0100;
    measuredAngle[2] = 16'h8000;
    idle(2);
    rdChk(OFS_ST_ANG, 16'h0000);
    measuredAngle[0] = 16'h0101;
    idle(2);
    check(16'(angleAlertVectorIrq), 16'h0001);
    measuredAngle[1] = 16'hFE00;
    idle(2);
    rdChk(OFS_ST_ANG, 16'h0001);
    idle(2);
    rdChk(OFS_ST_ANG, 16'h0002);
    rdChk(OFS_ST_ANG, 16'h0000);
    host.wr(OFS_ALERTINI, 16'h0001);
    measuredAngle[1] = 16'h4000;
    idle(2);
    rdChk(OFS_ST_ANG, 16'h0000);
    $display("angle test done");
  endtask

  initial begin
    rst_b = 1'b0;
    bitFailRaw = 4'h0;
    signalPresent = 4'hF;
    referencePresent = 4'hF;
    measuredAngle = '0;
    trackRate = '0;
    initiatedFullTest = 1'b0;
    initiatedFixedAngleTest = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    rst_b = 1'b1;
    test_reset();
    test_config();
    test_velocity();
    test_bit();
    test_loss();
    test_angle();
    final_report();
  end
endmodule
